/* File: hw/vsd_regs.vh */
// constants for the two-lane simd integer datapath
`ifndef VSD_REGS_VH
`define VSD_REGS_VH

// ************************************************************
// instruction fields (bit 0 is the msb of the 32-bit word)
// ************************************************************
`define VSD_PRIMARY_OP      6'h04
`define VSD_EXT_ADDW        11'h200
`define VSD_EXT_MHE_ACC     11'h509
`define VSD_EXT_MHE_LOAD    11'h529
`define VSD_EXT_MHE_MODACC  11'h50b

// ************************************************************
// lane layout and timing
// ************************************************************
`define VSD_LANE_W          32
`define VSD_REG_W           64
`define VSD_ACC_RESET       64'h0000000000000000
`define VSD_MUL_LATENCY     3
// wait cycles a dependent sees after a multiply issues (latency minus one)
`define VSD_MUL_WAIT        2'h2

`endif

/* File: hw/vsd_lane.v */
// one 32-bit lane: modulo add and signed even-halfword product
`timescale 1ns/1ps

module vsd_lane (
    input  wire [31:0] a_in,
    input  wire [31:0] b_in,
    input  wire [31:0] acc_in,
    output wire [31:0] sum_out,
    output wire [31:0] prod_out,
    output wire [31:0] mac_out
);

    // ************************************************************
    // lane arithmetic
    // ************************************************************
    wire signed [15:0] a_even;
    wire signed [15:0] b_even;
    wire signed [31:0] prod;

    // even halfword is the upper half of the lane
    assign a_even   = a_in[31:16];                   // [RULE10]
    assign b_even   = b_in[31:16];                   // [RULE10]
    assign prod     = a_even * b_even;               // [RULE14]
    // 32-bit targets drop the carry so nothing reaches the other lane
    assign sum_out  = a_in + b_in;                   // [RULE7] [RULE5]
    assign prod_out = prod;
    assign mac_out  = acc_in + prod;                 // [RULE14] [RULE5]

endmodule

/* File: hw/vsd_datapath.v */
// two-lane simd integer datapath sharing the core's in-order pipeline
`timescale 1ns/1ps
`include "vsd_regs.vh"

// How it works
// RULE1 - each 64-bit register is treated as two 32-bit lanes, with 16-bit halves used by multiply.
// RULE2 - bits 63:32 are the even (upper) lane and bits 31:0 are the odd (lower) lane.
// RULE3 - a vector instruction writes all 64 bits of its destination register.
// RULE4 - scalar instructions use only the low 32 bits; only vector ones use all 64. Here a scalar write also zeroes bits 63:32 of its destination.
// RULE5 - each lane is computed on its own with no carry passing between lanes.
// RULE6 - operands come from matching lanes of two sources and the accumulator; results go to dest, acc or both.
// RULE7 - vector add-words sums each lane modulo 2^32 without saturation.
// RULE8 - vector add-words finishes both lane sums in one execute cycle.
// RULE9 - the multiply-accumulate is opcode 4 in bits 0-5 and 101 0000 1001 in bits 21-31, with fields at 6-10, 11-15, 16-20.
// RULE10 - the multiply takes the signed even (upper) halfword of each lane of both sources.
// RULE11 - one variant loads the accumulator with the product, the add variant adds it and also writes the destination.
// RULE12 - vector work runs in the core's single in-order pipeline, one instruction at a time.
// RULE13 - multiplies issue every cycle but a dependent instruction waits three cycles after issue.
// RULE14 - products are 32-bit two's complement and the accumulate wraps modulo 2^32.
module vsd_datapath (
    input  wire        clk_in,
    input  wire        rst_b_in,
    input  wire        issue_valid_in,
    input  wire [31:0] instr_in,
    input  wire        scalar_in,
    input  wire [63:0] src_a_in,
    input  wire [63:0] src_b_in,
    output wire        issue_ready_out,
    output wire [4:0]  source_a_reg_field_out,
    output wire [4:0]  source_b_reg_field_out,
    output reg         wr_en_out,
    output reg  [4:0]  wr_addr_out,
    output reg  [63:0] wr_data_out,
    output reg  [63:0] acc_out,
    output reg         illegal_out
);

    // ************************************************************
    // decode
    // ************************************************************
    // instruction bit n of the documented big-endian numbering is instr_in[31-n]
    wire [5:0]  prim_op;
    wire [4:0]  dest_fld;
    wire [10:0] ext_op;
    wire        is_vec;
    wire        is_addw;
    wire        is_mac;
    wire        is_mac_load;
    wire        is_mac_mod;

    assign prim_op     = instr_in[31:26];                                // [RULE9]
    assign dest_fld    = instr_in[25:21];                                // [RULE9]
    assign source_a_reg_field_out = instr_in[20:16];                     // [RULE9]
    assign source_b_reg_field_out = instr_in[15:11];                     // [RULE9]
    assign ext_op      = instr_in[10:0];                                 // [RULE9]
    assign is_vec      = (prim_op == `VSD_PRIMARY_OP);
    assign is_addw     = is_vec && (ext_op == `VSD_EXT_ADDW);
    assign is_mac      = is_vec && (ext_op == `VSD_EXT_MHE_ACC);         // [RULE9]
    assign is_mac_load = is_vec && (ext_op == `VSD_EXT_MHE_LOAD);
    assign is_mac_mod  = is_vec && (ext_op == `VSD_EXT_MHE_MODACC);

    // ************************************************************
    // hazard scoreboard
    // ************************************************************
    // per-register countdown of cycles until a multiply result may be used;
    // the accumulator has its own slot because the mac reads it back
    reg  [1:0]  busy_cnt [0:31];
    reg  [1:0]  acc_busy;
    wire        any_mul;
    wire        hazard;
    integer     i;

    assign any_mul = is_mac || is_mac_load || is_mac_mod;
    // stall while a source, or the accumulator for accumulating forms, is pending
    assign hazard  = (busy_cnt[source_a_reg_field_out] != 2'h0) ||
                     (busy_cnt[source_b_reg_field_out] != 2'h0) ||
                     ((is_mac || is_mac_mod) && (acc_busy != 2'h0));    // [RULE13]
    assign issue_ready_out = !hazard;                                    // [RULE12]

    always @(posedge clk_in) begin
        if (!rst_b_in) begin
            for (i = 0; i < 32; i = i + 1) begin
                busy_cnt[i] <= 2'h0;
            end
            acc_busy <= 2'h0;
        end else begin
            for (i = 0; i < 32; i = i + 1) begin
                if (busy_cnt[i] != 2'h0) begin
                    busy_cnt[i] <= busy_cnt[i] - 2'h1;
                end
            end
            if (acc_busy != 2'h0) begin
                acc_busy <= acc_busy - 2'h1;
            end
            // result usable three cycles after issue: two more wait cycles
            // every multiply form writes its destination, so each one marks it busy
            if (issue_valid_in && !hazard && !scalar_in && any_mul) begin
                acc_busy           <= `VSD_MUL_WAIT;                     // [RULE13]
                busy_cnt[dest_fld] <= `VSD_MUL_WAIT;                     // [RULE13]
            end
        end
    end

    // ************************************************************
    // lanes
    // ************************************************************
    wire [31:0] sum_hi;
    wire [31:0] sum_lo;
    wire [31:0] prod_hi;
    wire [31:0] prod_lo;
    wire [31:0] mac_hi;
    wire [31:0] mac_lo;

    // upper word is the even lane, lower word the odd lane
    vsd_lane u_even (                                                    // [RULE2] [RULE1]
        .a_in     (src_a_in[63:32]),
        .b_in     (src_b_in[63:32]),
        .acc_in   (acc_out[63:32]),
        .sum_out  (sum_hi),
        .prod_out (prod_hi),
        .mac_out  (mac_hi)
    );

    vsd_lane u_odd (                                                     // [RULE2] [RULE1]
        .a_in     (src_a_in[31:0]),
        .b_in     (src_b_in[31:0]),
        .acc_in   (acc_out[31:0]),
        .sum_out  (sum_lo),
        .prod_out (prod_lo),
        .mac_out  (mac_lo)
    );

    // ************************************************************
    // result select and write-back
    // ************************************************************
    reg         next_wr_en;
    reg  [63:0] next_wr_data;
    reg  [63:0] next_acc;
    reg         next_illegal;
    wire [31:0] scalar_sum;

    // scalar add only ever sees the low word
    assign scalar_sum = src_a_in[31:0] + src_b_in[31:0];                 // [RULE4]

    always @* begin
        next_wr_en   = 1'b0;
        next_wr_data = wr_data_out;
        next_acc     = acc_out;
        next_illegal = 1'b0;
        if (issue_valid_in && !hazard) begin
            if (scalar_in) begin
                // upper word left as zero; a scalar write clears the even lane of its destination
                next_wr_en   = 1'b1;
                next_wr_data = {32'h0, scalar_sum};                      // [RULE4]
            end else if (is_addw) begin
                next_wr_en   = 1'b1;
                next_wr_data = {sum_hi, sum_lo};                         // [RULE8] [RULE3]
            end else if (is_mac_load) begin
                next_wr_en   = 1'b1;
                next_wr_data = {prod_hi, prod_lo};                       // [RULE3] [RULE6]
                next_acc     = {prod_hi, prod_lo};                       // [RULE11]
            end else if (is_mac || is_mac_mod) begin
                next_wr_en   = 1'b1;
                next_wr_data = {mac_hi, mac_lo};                         // [RULE11] [RULE3]
                next_acc     = {mac_hi, mac_lo};                         // [RULE11] [RULE6]
            end else begin
                next_illegal = 1'b1;
            end
        end
    end

    // single execute stage: one instruction retires per accepted cycle
    always @(posedge clk_in) begin
        if (!rst_b_in) begin
            wr_en_out   <= 1'b0;
            wr_addr_out <= 5'h00;
            wr_data_out <= 64'h0;
            acc_out     <= `VSD_ACC_RESET;
            illegal_out <= 1'b0;
        end else begin
            wr_en_out   <= next_wr_en;                                   // [RULE12]
            wr_addr_out <= dest_fld;
            wr_data_out <= next_wr_data;
            acc_out     <= next_acc;
            illegal_out <= next_illegal;
        end
    end

endmodule

/* File: testbench/vsd_props.sv */
// assertion checker for the two-lane simd datapath
`timescale 1ns/1ps
`include "vsd_regs.vh"
module vsd_props (
    input wire        clk_in,
    input wire        rst_b_in,
    input wire        issue_valid_in,
    input wire [31:0] instr_in,
    input wire        scalar_in,
    input wire [63:0] src_a_in,
    input wire [63:0] src_b_in,
    input wire        issue_ready_out,
    input wire [4:0]  source_a_reg_field_out,
    input wire [4:0]  source_b_reg_field_out,
    input wire        wr_en_out,
    input wire [4:0]  wr_addr_out,
    input wire [63:0] wr_data_out,
    input wire [63:0] acc_out,
    input wire        illegal_out
);
    // taken instruction and its class
    wire        tk = issue_valid_in && issue_ready_out;
    wire        vec = tk && !scalar_in && instr_in[31:26] == `VSD_PRIMARY_OP;
    wire [10:0] ex = instr_in[10:0];
    wire        acc_op = ex == `VSD_EXT_MHE_ACC || ex == `VSD_EXT_MHE_MODACC;
    wire        mt = vec && (acc_op || ex == `VSD_EXT_MHE_LOAD);
    reg  [63:0] a_q;
    reg  [63:0] b_q;
    // operands kept one cycle so results can be tied to them
    always @(posedge clk_in) begin
        a_q <= src_a_in;
        b_q <= src_b_in;
    end
    function [31:0] p(input [15:0] x, input [15:0] y);
        p = $signed(x) * $signed(y);
    endfunction
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    // ************************************************************
    // properties
    // ************************************************************
    addw_sum_a: assert property (vec && ex == `VSD_EXT_ADDW |=> wr_en_out &&
        wr_data_out == {a_q[63:32] + b_q[63:32], a_q[31:0] + b_q[31:0]}) else $error("lane sum");
    dest_addr_a: assert property (vec && ex == `VSD_EXT_ADDW |=>
        wr_addr_out == $past(instr_in[25:21])) else $error("dest addr");
    scalar_low_a: assert property (tk && scalar_in |=> wr_en_out &&
        wr_data_out == {32'h0, a_q[31:0] + b_q[31:0]}) else $error("scalar add");
    mac_load_a: assert property (vec && ex == `VSD_EXT_MHE_LOAD |=>
        acc_out == {p(a_q[63:48], b_q[63:48]), p(a_q[31:16], b_q[31:16])}) else $error("mac load");
    mac_accum_a: assert property (vec && acc_op |=> acc_out == wr_data_out &&
        acc_out == {$past(acc_out[63:32]) + p(a_q[63:48], b_q[63:48]),
        $past(acc_out[31:0]) + p(a_q[31:16], b_q[31:16])}) else $error("mac accumulate");
    field_dec_a: assert property (source_a_reg_field_out == instr_in[20:16] &&
        source_b_reg_field_out == instr_in[15:11]) else $error("field decode");
    bad_op_a: assert property (tk && !scalar_in && instr_in[31:26] != `VSD_PRIMARY_OP
        |=> illegal_out && !wr_en_out) else $error("illegal flag");
    no_issue_a: assert property (!tk |=> !wr_en_out && !illegal_out)
        else $error("write without issue");
    stall_src_a: assert property (!issue_ready_out |-> $past(mt) || $past(mt, 2))
        else $error("stall without multiply");
    cover property (mt ##1 !issue_ready_out);
    cover property (vec && ex == `VSD_EXT_ADDW);
    cover property (illegal_out);
endmodule

/* File: testbench/vsd_rf_model.sv */
// register file model feeding operands and taking write-back
`timescale 1ns/1ps
module vsd_rf_model (
    input  wire        clk_in,
    input  wire [4:0]  ra_in,
    input  wire [4:0]  rb_in,
    input  wire        we_in,
    input  wire [4:0]  wa_in,
    input  wire [63:0] wd_in,
    output wire [63:0] a_out,
    output wire [63:0] b_out
);
    reg [63:0] mem [0:31];
    // both operands read in the decode cycle, whole 64 bits
    assign a_out = mem[ra_in];
    assign b_out = mem[rb_in];
    // write-back commits the full register
    always @(posedge clk_in) if (we_in) mem[wa_in] <= wd_in;
endmodule

/* File: testbench/vector_simd_integer_datapath_tb.sv */
// self-checking bench for the two-lane simd datapath
`timescale 1ns/1ps
`include "vsd_regs.vh"
module vector_simd_integer_datapath_tb;
    reg         clk_in = 0, rst_b_in = 0, issue_valid_in = 0, scalar_in = 0;
    reg  [31:0] instr_in = 0;
    wire [63:0] src_a_in, src_b_in, wr_data_out, acc_out;
    wire [4:0]  source_a_reg_field_out, source_b_reg_field_out, wr_addr_out;
    wire        issue_ready_out, wr_en_out, illegal_out;
    integer     error_cnt = 0, n_compared = 0, st;
    vsd_datapath uut (.*);
    vsd_rf_model rf (.clk_in(clk_in), .ra_in(source_a_reg_field_out),
        .rb_in(source_b_reg_field_out), .we_in(wr_en_out), .wa_in(wr_addr_out),
        .wd_in(wr_data_out), .a_out(src_a_in), .b_out(src_b_in));
    initial forever #12.5 clk_in = ~clk_in;
    // ************************************************************
    // helpers
    // ************************************************************
    function [31:0] ins(input [4:0] d, input [4:0] a, input [4:0] b, input [10:0] x);
        ins = {`VSD_PRIMARY_OP, d, a, b, x};
    endfunction
    task chk(input string nm, input [63:0] exp, input [63:0] got);
        n_compared = n_compared + 1;
        if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // offer at a falling edge, count refused cycles, return after the taking edge
    task issue(input [31:0] w, input sc, output integer n);
        issue_valid_in = 1;
        instr_in = w;
        scalar_in = sc;
        #1 n = 0;
        while (issue_ready_out !== 1'b1 && n < 8) begin
            @(negedge clk_in);
            #1 n = n + 1;
        end
        @(negedge clk_in);
    endtask
    // ************************************************************
    // scenarios
    // ************************************************************
    task t_add;
        @(negedge clk_in);
        rf.mem[10] = 64'h7fffffff_ffffffff;
        rf.mem[11] = 64'h00000001_00000001;
        issue(ins(12, 10, 11, `VSD_EXT_ADDW), 0, st);
        chk("wr_en", 1, wr_en_out);
        chk("wr_addr", 12, wr_addr_out);
        chk("sum", 64'h80000000_00000000, wr_data_out);
        issue_valid_in = 0;
    endtask
    task t_scalar;
        @(negedge clk_in);
        issue(ins(13, 10, 10, 0), 1, st);
        chk("scalar", 64'h00000000_fffffffe, wr_data_out);
        issue_valid_in = 0;
        scalar_in = 0;
    endtask
    task t_mac;
        @(negedge clk_in);
        rf.mem[3] = 64'hfffe1234_00035678;
        rf.mem[4] = 64'h0005abcd_fff9ffff;
        issue(ins(1, 3, 4, `VSD_EXT_MHE_LOAD), 0, st);
        chk("acc load", 64'hfffffff6_ffffffeb, acc_out);
        issue(ins(5, 3, 4, `VSD_EXT_MHE_ACC), 0, st);
        chk("acc stall", 2, st);
        chk("acc add", 64'hffffffec_ffffffd6, wr_data_out);
        issue(ins(6, 3, 4, `VSD_EXT_MHE_MODACC), 0, st);
        chk("mod acc", 64'hffffffe2_ffffffc1, acc_out);
        issue(ins(7, 3, 4, `VSD_EXT_ADDW), 0, st);
        chk("indep stall", 0, st);
        chk("indep sum", 64'h0003be01_fffd5677, wr_data_out);
        issue(ins(8, 6, 3, `VSD_EXT_ADDW), 0, st);
        chk("dep stall", 1, st);
        chk("dep sum", 64'hfffe1216_00035639, wr_data_out);
        issue_valid_in = 0;
    endtask
    task t_illegal;
        @(negedge clk_in);
        issue({6'h1f, 26'h0}, 0, st);
        chk("illegal", 1, illegal_out);
        chk("no write", 0, wr_en_out);
        issue_valid_in = 0;
    endtask
    task end_of_test;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (4) @(negedge clk_in);
        rst_b_in = 1;
        t_add;
        t_scalar;
        t_mac;
        t_illegal;
        end_of_test;
    end
    // the sequence needs well under 100 cycles
    initial begin
        #(25 * 2000);
        error_cnt = error_cnt + 1;
        end_of_test;
    end
endmodule
bind vsd_datapath vsd_props chk_i (.*);
